// ===== logic/tdc_ctrl.sv
// Two-channel transfer controller: registers, enables, byte engine, request.
// Assumes CPU register port on same clock; bus done, requests and NMI are pins.
`timescale 1ns/1ps
module tdc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // CPU register port
    input wire tdc_pkg::tdc_regreq_t reg_req,
    output logic [7:0] reg_rdata,
    // External events
    input wire logic nmi_taken,
    input wire logic [1:0] xfer_request,
    input wire logic cpu_global_irq_flag,
    // Bus side
    input wire logic bus_done,
    output tdc_pkg::tdc_xfer_t xfer,
    output logic bus_hold,
    // Interrupt
    output logic [1:0] term_irq
);
    logic [2:0] pin_s;
    logic nmi_s;
    logic [1:0] dreq_s;
    logic bus_done_s;
    logic [19:0] ch0_source_address_q;
    logic [19:0] ch0_destination_address_q;
    logic [15:0] ch0_byte_count_q;
    logic [19:0] ch1_memory_address_q;
    logic [15:0] ch1_io_address_q;
    logic [15:0] ch1_byte_count_q;
    logic [1:0] run_enable_q;
    logic [1:0] channel_irq_enable_q;
    logic [1:0] dst_io_q;
    logic master_transfer_enable_q;
    tdc_pkg::tdc_state_t state_q;
    logic [7:0] off;
    logic [7:0] stat_rd;
    logic [7:0] rd_d;
    logic [1:0] go;
    logic byte_end;
    logic wr_stat;
    logic [1:0] fin;

    tdc_sync #(.W(3)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({nmi_taken, xfer_request}),
        .q(pin_s)
    );
    assign nmi_s = pin_s[2];
    assign dreq_s = pin_s[1:0];

    tdc_sync #(.W(1)) u_sync_done (
        .clk(clk),
        .rst(rst),
        .d(bus_done),
        .q(bus_done_s)
    );

    assign off = {2'b00, reg_req.addr[5:0] & tdc_pkg::IO_PAGE_MASK};
    assign wr_stat = reg_req.wr && off == tdc_pkg::ADR_STAT;
    assign go[0] = run_enable_q[0] && master_transfer_enable_q && dreq_s[0];
    assign go[1] = run_enable_q[1] && master_transfer_enable_q && dreq_s[1];
    assign byte_end = bus_done_s && state_q != tdc_pkg::ST_IDLE;
    assign fin[0] = byte_end && state_q == tdc_pkg::ST_CH0 && ch0_byte_count_q == tdc_pkg::CNT_ONE;
    assign fin[1] = byte_end && state_q == tdc_pkg::ST_CH1 && ch1_byte_count_q == tdc_pkg::CNT_ONE;

    // Byte engine; master loss aborts after current byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= tdc_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                tdc_pkg::ST_IDLE: begin
                    if (go[0] && !nmi_s) begin
                        state_q <= tdc_pkg::ST_CH0;
                    end else if (go[1] && !nmi_s) begin
                        state_q <= tdc_pkg::ST_CH1;
                    end
                end
                tdc_pkg::ST_CH0, tdc_pkg::ST_CH1: begin
                    if (bus_done_s) begin
                        state_q <= tdc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Address registers, bank byte holds top bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch0_source_address_q <= '0;
            ch0_destination_address_q <= '0;
            ch1_memory_address_q <= '0;
            ch1_io_address_q <= '0;
            dst_io_q <= '0;
        end else begin
            // Increments first, so an unrelated write never drops a step
            if (byte_end && state_q == tdc_pkg::ST_CH0) begin
                ch0_source_address_q <= ch0_source_address_q + tdc_pkg::MEM_STEP;
                if (!dst_io_q[0]) begin
                    ch0_destination_address_q <= ch0_destination_address_q + tdc_pkg::MEM_STEP;
                end
            end
            if (byte_end && state_q == tdc_pkg::ST_CH1) begin
                ch1_memory_address_q <= ch1_memory_address_q + tdc_pkg::MEM_STEP;
            end
            if (reg_req.wr) begin
                unique case (off)
                    tdc_pkg::ADR_SRC0: ch0_source_address_q[7:0] <= reg_req.wdata;
                    tdc_pkg::ADR_SRC0 + 8'h01: begin
                        ch0_source_address_q[15:8] <= reg_req.wdata;
                    end
                    tdc_pkg::ADR_SRC0 + 8'h02: ch0_source_address_q[19:16] <= reg_req.wdata[3:0];
                    tdc_pkg::ADR_DST0: ch0_destination_address_q[7:0] <= reg_req.wdata;
                    tdc_pkg::ADR_DST0 + 8'h01: ch0_destination_address_q[15:8] <= reg_req.wdata;
                    tdc_pkg::ADR_DST0 + 8'h02: begin
                        ch0_destination_address_q[19:16] <= reg_req.wdata[3:0];
                    end
                    tdc_pkg::ADR_MEM1: ch1_memory_address_q[7:0] <= reg_req.wdata;
                    tdc_pkg::ADR_MEM1 + 8'h01: ch1_memory_address_q[15:8] <= reg_req.wdata;
                    tdc_pkg::ADR_MEM1 + 8'h02: ch1_memory_address_q[19:16] <= reg_req.wdata[3:0];
                    tdc_pkg::ADR_IO1: ch1_io_address_q[7:0] <= reg_req.wdata;
                    tdc_pkg::ADR_IO1 + 8'h01: ch1_io_address_q[15:8] <= reg_req.wdata;
                    tdc_pkg::ADR_STAT + 8'h01: dst_io_q <= reg_req.wdata[1:0];
                    default: ;
                endcase
            end
        end
    end

    // Byte counters, CPU write wins over decrement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch0_byte_count_q <= tdc_pkg::CNT_ZERO;
            ch1_byte_count_q <= tdc_pkg::CNT_ZERO;
        end else begin
            if (reg_req.wr && off == tdc_pkg::ADR_CNT0) begin
                ch0_byte_count_q[7:0] <= reg_req.wdata;
            end else if (reg_req.wr && off == tdc_pkg::ADR_CNT0 + 8'h01) begin
                ch0_byte_count_q[15:8] <= reg_req.wdata;
            end else if (byte_end && state_q == tdc_pkg::ST_CH0) begin
                ch0_byte_count_q <= ch0_byte_count_q - tdc_pkg::CNT_ONE;
            end
            if (reg_req.wr && off == tdc_pkg::ADR_CNT1) begin
                ch1_byte_count_q[7:0] <= reg_req.wdata;
            end else if (reg_req.wr && off == tdc_pkg::ADR_CNT1 + 8'h01) begin
                ch1_byte_count_q[15:8] <= reg_req.wdata;
            end else if (byte_end && state_q == tdc_pkg::ST_CH1) begin
                ch1_byte_count_q <= ch1_byte_count_q - tdc_pkg::CNT_ONE;
            end
        end
    end

    // Channel enables: hardware only clears, write-enable bits gate run-enable writes; irq enables are written on every status write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_enable_q <= '0;
            channel_irq_enable_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (fin[i]) begin
                    run_enable_q[i] <= 1'b0;
                end else if (wr_stat && !reg_req.wdata[tdc_pkg::STAT_WEN0 + i]) begin
                    run_enable_q[i] <= reg_req.wdata[tdc_pkg::STAT_RUN0 + i];
                end
            end
            if (wr_stat) begin
                channel_irq_enable_q <= reg_req.wdata[tdc_pkg::STAT_IEN1:tdc_pkg::STAT_IEN0];
            end
        end
    end

    // Master enable; NMI clear beats a set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_transfer_enable_q <= 1'b0;
        end else if (nmi_s) begin
            master_transfer_enable_q <= 1'b0;
        end else if (wr_stat && reg_req.wdata[tdc_pkg::STAT_MASTER]) begin
            master_transfer_enable_q <= 1'b1;
        end
    end

    // Read mux and registered outputs
    assign stat_rd = {run_enable_q, 2'b11, channel_irq_enable_q, 1'b0, master_transfer_enable_q};
    always_comb begin
        rd_d = 8'h00;
        unique case (off)
            tdc_pkg::ADR_SRC0: rd_d = ch0_source_address_q[7:0];
            tdc_pkg::ADR_SRC0 + 8'h01: rd_d = ch0_source_address_q[15:8];
            tdc_pkg::ADR_SRC0 + 8'h02: rd_d = {4'h0, ch0_source_address_q[19:16]};
            tdc_pkg::ADR_DST0: rd_d = ch0_destination_address_q[7:0];
            tdc_pkg::ADR_DST0 + 8'h01: rd_d = ch0_destination_address_q[15:8];
            tdc_pkg::ADR_DST0 + 8'h02: rd_d = {4'h0, ch0_destination_address_q[19:16]};
            tdc_pkg::ADR_CNT0: rd_d = ch0_byte_count_q[7:0];
            tdc_pkg::ADR_CNT0 + 8'h01: rd_d = ch0_byte_count_q[15:8];
            tdc_pkg::ADR_MEM1: rd_d = ch1_memory_address_q[7:0];
            tdc_pkg::ADR_MEM1 + 8'h01: rd_d = ch1_memory_address_q[15:8];
            tdc_pkg::ADR_MEM1 + 8'h02: rd_d = {4'h0, ch1_memory_address_q[19:16]};
            tdc_pkg::ADR_IO1: rd_d = ch1_io_address_q[7:0];
            tdc_pkg::ADR_IO1 + 8'h01: rd_d = ch1_io_address_q[15:8];
            tdc_pkg::ADR_CNT1: rd_d = ch1_byte_count_q[7:0];
            tdc_pkg::ADR_CNT1 + 8'h01: rd_d = ch1_byte_count_q[15:8];
            tdc_pkg::ADR_STAT: rd_d = stat_rd;
            tdc_pkg::ADR_STAT + 8'h01: rd_d = {6'h00, dst_io_q};
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            xfer <= '0;
            bus_hold <= 1'b0;
            term_irq <= '0;
        end else begin
            reg_rdata <= reg_req.rd ? rd_d : 8'h00;
            xfer.req <= state_q != tdc_pkg::ST_IDLE && !bus_done_s;
            xfer.dst_io <= state_q == tdc_pkg::ST_CH0 ? dst_io_q[0] : dst_io_q[1];
            xfer.dst_addr <= state_q == tdc_pkg::ST_CH1 ?
                (dst_io_q[1] ? {4'h0, ch1_io_address_q} : ch1_memory_address_q) :
                ch0_destination_address_q;
            xfer.src_addr <= state_q == tdc_pkg::ST_CH1 ?
                (dst_io_q[1] ? ch1_memory_address_q : {4'h0, ch1_io_address_q}) :
                ch0_source_address_q;
            bus_hold <= state_q != tdc_pkg::ST_IDLE;
            // Level request, taken by CPU when its global flag is set
            term_irq <= ~run_enable_q & channel_irq_enable_q
                & {2{cpu_global_irq_flag}};
        end
    end
endmodule

// ===== logic/tdc_pkg.sv
// Package for the two-channel transfer controller: offsets, fields, types.
// Assumes an 8-bit internal I/O register port driven by the CPU core.
// Contract
// - Channel 0 destination address is 20 bits, memory or I/O space.
// - Channel 0 destination may be memory, I/O port or memory-mapped I/O; code offers only incrementing memory or a fixed I/O port address.
// - Byte counters are 16 bits and drop by one per byte moved.
// - Channel 1 memory address is 20 bits, source or destination.
// - Channel 1 I/O address is 16 bits, source or destination.
// - Count reaching zero at operation end clears that channel's enable.
// - Cleared enable stays zero until software writes a one.
// - Termination request is a level while channel disabled and irq enabled; code also gates term_irq with cpu_global_irq_flag.
// - One write may set irq enable and channel enable; transfers resume.
// - Non-maskable interrupt clears master enable, suspending both channels.
// - Channel 0 source address sits at 20H to 22H, low, high, bank.
package tdc_pkg;
    localparam logic [7:0] ADR_SRC0 = 8'h20;
    localparam logic [7:0] ADR_DST0 = 8'h23;
    localparam logic [7:0] ADR_CNT0 = 8'h26;
    localparam logic [7:0] ADR_MEM1 = 8'h28;
    localparam logic [7:0] ADR_IO1 = 8'h2B;
    localparam logic [7:0] ADR_CNT1 = 8'h2E;
    localparam logic [7:0] ADR_STAT = 8'h30;
    localparam logic [5:0] IO_PAGE_MASK = 6'h3F;
    // Status register fields
    localparam int STAT_RUN1 = 7;
    localparam int STAT_RUN0 = 6;
    localparam int STAT_WEN1 = 5;
    localparam int STAT_WEN0 = 4;
    localparam int STAT_IEN1 = 3;
    localparam int STAT_IEN0 = 2;
    localparam int STAT_MASTER = 0;
    localparam int BANK_BITS = 4;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [19:0] MEM_STEP = 20'h00001;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tdc_regreq_t;

    typedef struct packed {
        logic req;
        logic dst_io;
        logic [19:0] dst_addr;
        logic [19:0] src_addr;
    } tdc_xfer_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CH0 = 3'b010,
        ST_CH1 = 3'b100
    } tdc_state_t;
endpackage

// ===== logic/tdc_sync.sv
// Two-flop synchroniser for pin-level inputs.
// Assumes a single clock domain, async active-high reset.
`timescale 1ns/1ps
module tdc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== verif/tdc_bus_model.sv
// Bus-side model: answers each byte request with a done pulse.
// Assumes the controller holds its request until done is seen.
`timescale 1ns/1ps
module tdc_bus_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    input wire tdc_pkg::tdc_xfer_t xfer,
    output logic bus_done,
    // Test control and status
    input wire logic [1:0] slow,
    output int nbytes,
    output logic [19:0] last_dst,
    output logic [19:0] last_src,
    output logic last_io
);
    logic [1:0] wait_q;
    logic served_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_done <= 1'b0;
            wait_q <= 2'b00;
            served_q <= 1'b0;
            nbytes <= 0;
            last_dst <= 20'h00000;
            last_src <= 20'h00000;
            last_io <= 1'b0;
        end else if (!xfer.req) begin
            bus_done <= 1'b0;
            wait_q <= slow;
            served_q <= 1'b0;
        end else if (wait_q != 2'b00) begin
            wait_q <= wait_q - 2'b01;
        end else begin
            bus_done <= !served_q;
            served_q <= 1'b1;
            if (!served_q) begin
                nbytes <= nbytes + 1;
                last_dst <= xfer.dst_addr;
                last_src <= xfer.src_addr;
                last_io <= xfer.dst_io;
            end
        end
    end
endmodule

// ===== verif/tdc_checker.sv
// Port checks for the transfer controller.
// Bound to tdc_ctrl from the bench top file.
`timescale 1ns/1ps
module tdc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire tdc_pkg::tdc_regreq_t reg_req,
    input wire logic nmi_taken,
    input wire logic [1:0] xfer_request,
    input wire logic cpu_global_irq_flag,
    input wire logic bus_done,
    // Outputs
    input wire logic [7:0] reg_rdata,
    input wire tdc_pkg::tdc_xfer_t xfer,
    input wire logic bus_hold,
    input wire logic [1:0] term_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_flag_low;
        !cpu_global_irq_flag ##1 !cpu_global_irq_flag;
    endsequence
    sequence s_nmi_held;
        nmi_taken [*5];
    endsequence
    sequence s_no_req;
        (xfer_request == 2'b00) [*6];
    endsequence
    a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_addr_steady: assert property ($past(xfer.req) && xfer.req |-> $stable(xfer.dst_addr))
        else $error("address moved during byte");
    a_hold_req: assert property (xfer.req |-> bus_hold)
        else $error("request without bus hold");
    a_flag_gate: assert property (s_flag_low |-> term_irq == 2'b00)
        else $error("irq with global flag low");
    a_irq_cause: assert property ($rose(term_irq[0]) || $rose(term_irq[1]) |-> $past(cpu_global_irq_flag))
        else $error("irq rose without flag");
    a_nmi_refuse: assert property (s_nmi_held |-> !$rose(xfer.req))
        else $error("start during nmi");
    a_req_refuse: assert property (s_no_req |-> !$rose(xfer.req))
        else $error("start without request");
    a_reset_quiet: assert property ($past(rst) |-> !xfer.req && !bus_hold && term_irq == 2'b00)
        else $error("outputs busy after reset");
endmodule

// ===== verif/tdc_ctrl_bench.sv
// Self-checking bench for the transfer controller.
// Assumes package, design, bus model and checker compiled first.
`timescale 1ns/1ps
module tdc_ctrl_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic nmi = 1'b0;
    logic flag = 1'b1;
    logic rd_d = 1'b0;
    logic done, hold, last_io;
    logic [1:0] want = 2'b00;
    logic [1:0] slow = 2'b00;
    logic [1:0] irq;
    logic [7:0] rdata;
    logic [7:0] shadow [16];
    logic [15:0] lfsr = 16'h002A;
    logic [15:0] note;
    logic [15:0] exp_q [$];
    logic [19:0] dst, last_dst, last_src, mem1;
    int nbytes, n0, n1;
    int n_mismatch = 0;
    int num_checks = 0;
    tdc_pkg::tdc_regreq_t req = '0;
    tdc_pkg::tdc_xfer_t xfer;
    always #2.5 clk = ~clk;
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] msk(input int i);
        return (i == 2 || i == 5 || i == 10) ? 8'h0F : 8'hFF;
    endfunction
    task automatic ck(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 500 && nbytes < n; i++) @(posedge clk);
        ck(20'(nbytes), 20'(n));
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        rd_d <= req.rd;
        if (rd_d && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            ck({12'h000, rdata & note[15:8]}, {12'h000, note[7:0]});
        end
    end
    tdc_ctrl uut (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .nmi_taken(nmi),
        .xfer_request(want), .cpu_global_irq_flag(flag), .bus_done(done), .xfer(xfer),
        .bus_hold(hold), .term_irq(irq));
    tdc_bus_model peer (.clk(clk), .rst(rst), .xfer(xfer), .bus_done(done), .slow(slow),
        .nbytes(nbytes), .last_dst(last_dst), .last_src(last_src), .last_io(last_io));
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(tdc_pkg::ADR_STAT, 8'hC5, tdc_pkg::STAT_RESET);
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            shadow[i] = (i == 13) ? 8'h00 : lfsr[7:0] & msk(i);
            wr(8'h20 + 8'(i), lfsr[7:0]);
        end
        for (int i = 0; i < 16; i++) rd(8'h20 + 8'(i), msk(i), shadow[i]);
        wr(tdc_pkg::ADR_CNT0, 8'h02);
        wr(tdc_pkg::ADR_CNT0 + 8'h01, 8'h00);
        wr(tdc_pkg::ADR_STAT, 8'h65);
        slow <= lfsr[1:0];
        want <= 2'b01;
        wait_bytes(2);
        ck({19'h00000, last_io}, 20'h00000);
        repeat (20) @(posedge clk);
        ck(20'(nbytes), 20'h00002);
        rd(tdc_pkg::ADR_CNT0, 8'hFF, 8'h00);
        rd(tdc_pkg::ADR_STAT, 8'h41, 8'h01);
        ck({19'h00000, irq[0]}, 20'h00001);
        flag <= 1'b0;
        repeat (3) @(posedge clk);
        ck({19'h00000, irq[0]}, 20'h00000);
        wr(tdc_pkg::ADR_STAT, 8'h31);
        flag <= 1'b1;
        repeat (3) @(posedge clk);
        ck({19'h00000, irq[0]}, 20'h00000);
        ck(20'(nbytes), 20'h00002);
        wr(tdc_pkg::ADR_STAT + 8'h01, 8'h03);
        dst = {lfsr[3:0], lfsr};
        wr(tdc_pkg::ADR_DST0, dst[7:0]);
        wr(tdc_pkg::ADR_DST0 + 8'h01, dst[15:8]);
        wr(tdc_pkg::ADR_DST0 + 8'h02, {4'h0, dst[19:16]});
        wr(tdc_pkg::ADR_CNT0, 8'h01);
        wr(tdc_pkg::ADR_STAT, 8'h65);
        wait_bytes(3);
        ck(last_dst, dst);
        ck({19'h00000, last_io}, 20'h00001);
        want <= 2'b00;
        n0 = nbytes;
        wr(tdc_pkg::ADR_CNT1, 8'h03);
        wr(tdc_pkg::ADR_CNT1 + 8'h01, 8'h00);
        slow <= 2'b11;
        wr(tdc_pkg::ADR_STAT, 8'h99);
        want <= 2'b10;
        wait_bytes(n0 + 1);
        nmi <= 1'b1;
        repeat (8) @(posedge clk);
        nmi <= 1'b0;
        repeat (40) @(posedge clk);
        n1 = nbytes;
        ck({19'h00000, hold}, 20'h00000);
        rd(tdc_pkg::ADR_STAT, 8'h81, 8'h80);
        rd(tdc_pkg::ADR_CNT1, 8'hFF, 8'(n0 + 3 - n1));
        repeat (40) @(posedge clk);
        ck(20'(nbytes), 20'(n1));
        wr(tdc_pkg::ADR_STAT, 8'h39);
        wait_bytes(n0 + 3);
        mem1 = {shadow[10][3:0], shadow[9], shadow[8]};
        ck(last_dst, {4'h0, shadow[12], shadow[11]});
        ck(last_src, mem1 + 20'h00002);
        ck({19'h00000, last_io}, 20'h00001);
        repeat (10) @(posedge clk);
        ck({18'h00000, irq}, 20'h00002);
        conclude();
    end
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule
bind tdc_ctrl tdc_checker chk (.clk(clk), .rst(rst), .reg_req(reg_req), .nmi_taken(nmi_taken),
    .xfer_request(xfer_request), .cpu_global_irq_flag(cpu_global_irq_flag),
    .bus_done(bus_done), .reg_rdata(reg_rdata), .xfer(xfer), .bus_hold(bus_hold),
    .term_irq(term_irq));
